// ---- hdl/sos_pkg.sv ----
// Purpose: shared constants and carrier types for the system oscillator select block
// Assumes: one 40 MHz clock; oscillators arrive as one-cycle tick enables
// Notes: control bits are plain ports, captured on write strobes
package sos_pkg;

  // clock rate of mclk
  localparam int unsigned CLK_HZ = 40000000;
  // crystal startup times in microseconds, low-power and speed-up
  localparam int unsigned LXT_START_LP_US = 1000000;
  localparam int unsigned LXT_START_SP_US = 200000;
  // startup counts in cycles, microseconds times whole cycles per microsecond
  localparam int unsigned LXT_START_LP_CYC = (LXT_START_LP_US * (CLK_HZ / 1000000));
  localparam int unsigned LXT_START_SP_CYC = (LXT_START_SP_US * (CLK_HZ / 1000000));
  // width of the startup counter
  localparam int unsigned START_CNT_W = 26;

  // clock select field values
  localparam logic [2:0] SEL_DIV1 = 3'h0;
  localparam logic [2:0] SEL_LOW = 3'h7;
  // high source encodings
  localparam logic HS_XTAL = 1'b0;
  localparam logic HS_RC = 1'b1;
  // low source encodings
  localparam logic LS_RC = 1'b0;
  localparam logic LS_XTAL = 1'b1;

  // reset values of the control bits
  localparam logic [2:0] SEL_RST = 3'h0;
  localparam logic HSRC_RST = HS_XTAL;
  localparam logic LSRC_RST = LS_RC;
  localparam logic LXT_EN_RST = 1'b0;
  localparam logic LXT_SP_RST = 1'b0;
  localparam logic FHIDEN_RST = 1'b0;
  localparam logic FSIDEN_RST = 1'b0;

  // divider width, enough for a divide by 64
  localparam int unsigned DIV_W = 6;

  // system clock control fields
  typedef struct packed {
    logic [2:0] sys_clk_select;  // divide code or low clock
    logic high_source_select;    // crystal or rc for the high path
    logic low_source_select;     // rc or crystal for the low path
    logic high_idle_en;          // keep high clock in halt
    logic low_idle_en;           // keep low clock in halt
  } sos_sys_ctrl_s;

  // low crystal control fields
  typedef struct packed {
    logic low_xtal_speedup;  // 1 quick start, 0 low power
    logic low_xtal_enable;   // crystal oscillator enable
  } sos_lxt_ctrl_s;

  // status seen by software
  typedef struct packed {
    logic low_xtal_ready;  // startup delay expired
    logic mode_locked;     // crystal clocks the system
    logic sys_on_low;      // system runs from the low path
    logic xt_pins_osc;     // crystal pins given to oscillator
  } sos_status_s;

endpackage : sos_pkg

// ---- hdl/sos_clk_div.sv ----
// Purpose: power-of-two divider of a tick enable
// Assumes: tick is a one-cycle enable on mclk
// Notes: output is combinational on the counted tick
`timescale 1ns/1ps
module sos_clk_div
  import sos_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic tick,
  input wire logic [2:0] div_code,
  output logic tick_out
);

  // running count of input ticks
  logic [DIV_W-1:0] cnt;
  // low bits that must all be ones for a pulse
  logic [DIV_W-1:0] mask;

  // mask has div_code ones from the bottom
  always_comb begin
    mask = DIV_W'((7'h01 << div_code) - 7'h01);
  end

  // count every input tick
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt <= '0;
    end else if (tick) begin
      cnt <= cnt + DIV_W'(1);
    end
  end

  // pulse once per 2^div_code ticks
  assign tick_out = tick && ((cnt & mask) == mask);

endmodule : sos_clk_div

// ---- hdl/sos_lxt_startup.sv ----
// Purpose: startup delay model of the low speed crystal
// Assumes: run is a level, speed-up picks the shorter count
// Notes: ready clears on the next mclk edge after run drops
`timescale 1ns/1ps
module sos_lxt_startup
  import sos_pkg::*;
#(
  parameter logic [START_CNT_W-1:0] LP_CYC = START_CNT_W'(LXT_START_LP_CYC),
  parameter logic [START_CNT_W-1:0] SP_CYC = START_CNT_W'(LXT_START_SP_CYC)
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic run,
  input wire logic speedup,
  output logic ready
);

  // cycles since the oscillator was enabled
  logic [START_CNT_W-1:0] cnt;
  // count at which the crystal counts as stable
  logic [START_CNT_W-1:0] target;

  assign target = speedup ? SP_CYC : LP_CYC;

  always_ff @(posedge mclk) begin
    if (rst || !run) begin
      cnt <= '0;
      ready <= 1'b0;
    end else if (!ready) begin
      if (cnt >= target - START_CNT_W'(1)) begin
        ready <= 1'b1;
      end else begin
        cnt <= cnt + START_CNT_W'(1);
      end
    end
  end

endmodule : sos_lxt_startup

// ---- hdl/sos_top.sv ----
// Purpose: system clock source and divider selection with low crystal control
// Assumes: oscillator ticks are one-cycle enables synchronous to mclk
// Notes: sys_clk_en is the gated system clock enable, registered
`timescale 1ns/1ps
module sos_top
  import sos_pkg::*;
#(
  parameter logic [START_CNT_W-1:0] LXT_LP_CYC = START_CNT_W'(LXT_START_LP_CYC),
  parameter logic [START_CNT_W-1:0] LXT_SP_CYC = START_CNT_W'(LXT_START_SP_CYC)
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sys_ctrl_wr,
  input wire sos_sys_ctrl_s sys_ctrl_wdata,
  input wire logic lxt_ctrl_wr,
  input wire sos_lxt_ctrl_s lxt_ctrl_wdata,
  input wire logic xt_pin_func_osc,
  input wire logic halt,
  input wire logic high_xtal_tick,
  input wire logic high_rc_tick,
  input wire logic low_xtal_tick,
  input wire logic low_rc_tick,
  output sos_sys_ctrl_s sys_ctrl,
  output sos_lxt_ctrl_s lxt_ctrl,
  output sos_status_s status,
  output logic sys_clk_en,
  output logic high_clk_en,
  output logic low_clk_en,
  output logic low_xtal_run
);

  // crystal startup done
  logic lxt_ready;
  // crystal drives system clock, mode frozen
  logic mode_lock;
  // selected high speed tick
  logic high_tick;
  // selected low speed tick
  logic low_tick;
  // high tick after divider
  logic high_div_tick;
  // system tick before halt gating
  logic sys_tick;
  // high path kept alive
  logic high_keep;
  // low path kept alive
  logic low_keep;

  // system clock control register
  always_ff @(posedge mclk) begin
    if (rst) begin
      sys_ctrl.high_source_select <= HSRC_RST;
      sys_ctrl.sys_clk_select <= SEL_RST;
      sys_ctrl.low_source_select <= LSRC_RST;
      sys_ctrl.high_idle_en <= FHIDEN_RST;
      sys_ctrl.low_idle_en <= FSIDEN_RST;
    end else if (sys_ctrl_wr) begin
      sys_ctrl <= sys_ctrl_wdata;
    end
  end

  assign mode_lock = (sys_ctrl.sys_clk_select == SEL_LOW) && (sys_ctrl.low_source_select == LS_XTAL);

  // low crystal enable bit
  always_ff @(posedge mclk) begin
    if (rst) begin
      lxt_ctrl.low_xtal_enable <= LXT_EN_RST;
    end else if (lxt_ctrl_wr) begin
      lxt_ctrl.low_xtal_enable <= lxt_ctrl_wdata.low_xtal_enable;
    end
  end

  // low crystal mode bit
  always_ff @(posedge mclk) begin
    if (rst) begin
      lxt_ctrl.low_xtal_speedup <= LXT_SP_RST;
    end else if (lxt_ctrl_wr && !mode_lock) begin
      lxt_ctrl.low_xtal_speedup <= lxt_ctrl_wdata.low_xtal_speedup;
    end
  end

  // pins must be given to oscillator
  assign low_xtal_run = lxt_ctrl.low_xtal_enable && xt_pin_func_osc;

  // startup delay of the crystal
  sos_lxt_startup #(
    .LP_CYC(LXT_LP_CYC),
    .SP_CYC(LXT_SP_CYC)
  ) u_startup (
    .mclk(mclk),
    .rst(rst),
    .run(low_xtal_run),
    .speedup(lxt_ctrl.low_xtal_speedup),
    .ready(lxt_ready)
  );

  assign high_tick = (sys_ctrl.high_source_select == HS_RC) ? high_rc_tick : high_xtal_tick;

  // crystal usable once started, any mode
  assign low_tick = (sys_ctrl.low_source_select == LS_XTAL) ? (low_xtal_tick && lxt_ready) : low_rc_tick;

  // divider for the high path
  sos_clk_div u_div (
    .mclk(mclk),
    .rst(rst),
    .tick(high_tick),
    .div_code(sys_ctrl.sys_clk_select),
    .tick_out(high_div_tick)
  );

  assign sys_tick = (sys_ctrl.sys_clk_select == SEL_LOW) ? low_tick : high_div_tick;

  // peripheral clocks survive halt when their idle bits say so
  assign high_keep = !halt || sys_ctrl.high_idle_en;
  assign low_keep = !halt || sys_ctrl.low_idle_en;

  always_ff @(posedge mclk) begin
    if (rst) begin
      sys_clk_en <= 1'b0;
    end else begin
      sys_clk_en <= sys_tick && !halt;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      high_clk_en <= 1'b0;
      low_clk_en <= 1'b0;
    end else begin
      high_clk_en <= high_tick && high_keep;
      low_clk_en <= low_tick && low_keep;
    end
  end

  // status for software
  always_ff @(posedge mclk) begin
    if (rst) begin
      status <= '0;
    end else begin
      status.low_xtal_ready <= lxt_ready;
      status.mode_locked <= mode_lock;
      status.sys_on_low <= (sys_ctrl.sys_clk_select == SEL_LOW);
      status.xt_pins_osc <= xt_pin_func_osc;
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // helper: pure tick conditions
  sequence s_low_rc_osc_sys;
    !halt && sys_ctrl.sys_clk_select == SEL_LOW && sys_ctrl.low_source_select == LS_RC && low_rc_tick;
  endsequence

  sequence s_hxt_div1;
    !halt && sys_ctrl.sys_clk_select == SEL_DIV1 && sys_ctrl.high_source_select == HS_XTAL && high_xtal_tick;
  endsequence

  sequence s_high_rc_osc_div1;
    !halt && sys_ctrl.sys_clk_select == SEL_DIV1 && sys_ctrl.high_source_select == HS_RC && high_rc_tick;
  endsequence

  chk_halt_gates: assert property (halt |=> !sys_clk_en)
    else $error("system clock ran during halt");

  chk_low_rc_path: assert property (s_low_rc_osc_sys |=> sys_clk_en)
    else $error("low rc tick not passed to system clock");

  chk_high_xtal_path: assert property (s_hxt_div1 |=> sys_clk_en)
    else $error("undivided crystal tick lost");

  chk_high_rc_path: assert property (s_high_rc_osc_div1 |=> sys_clk_en)
    else $error("undivided rc tick lost");

  chk_mode_frozen: assert property (mode_lock && !sys_ctrl_wr |=> $stable(lxt_ctrl.low_xtal_speedup))
    else $error("crystal mode changed while locked");

  chk_mode_write: assert property (lxt_ctrl_wr && !mode_lock |=>
      lxt_ctrl.low_xtal_speedup == $past(lxt_ctrl_wdata.low_xtal_speedup))
    else $error("crystal mode write lost");

  chk_start_delay: assert property ($rose(low_xtal_run) |-> !lxt_ready [*2])
    else $error("crystal ready without startup delay");

  chk_ready_needs_run: assert property (lxt_ready |-> $past(low_xtal_run))
    else $error("crystal ready while stopped");

  chk_unready_xtal: assert property (!lxt_ready |-> !(low_tick && sys_ctrl.low_source_select == LS_XTAL))
    else $error("unstarted crystal drove low path");

  chk_reset_hsrc: assert property ($past(rst) |-> sys_ctrl.high_source_select == HS_XTAL)
    else $error("high source not crystal after reset");

  chk_run_pins: assert property (low_xtal_run |-> xt_pin_func_osc)
    else $error("crystal runs without its pins");

  chk_sel_write: assert property (sys_ctrl_wr |=> sys_ctrl == $past(sys_ctrl_wdata))
    else $error("clock select write lost");

endmodule : sos_top

// ---- tb/system_oscillator_select_bench.sv ----
// Purpose: self-checking bench for the system oscillator select block
// Assumes: sos_top with short startup counts; ticks driven as one-cycle enables
// Notes: seeded random control writes plus hand-picked divider and crystal cases
`timescale 1ns/1ps
module system_oscillator_select_bench
  import sos_pkg::*;
;
  localparam int LP = 20; // short low-power startup
  localparam int SP = 5; // short speed-up startup
  logic mclk, rst, sys_ctrl_wr, lxt_ctrl_wr, xt_pin_func_osc, halt;
  sos_sys_ctrl_s sys_ctrl_wdata, sys_ctrl, d;
  sos_lxt_ctrl_s lxt_ctrl_wdata, lxt_ctrl;
  sos_status_s status;
  logic [3:0] ticks; // high xtal, high rc, low xtal, low rc
  logic sys_clk_en, high_clk_en, low_clk_en, low_xtal_run;
  int fail_count, cmp_count, sys_cnt, hi_cnt, lo_cnt, n, seed;

  sos_top #(.LXT_LP_CYC(START_CNT_W'(LP)), .LXT_SP_CYC(START_CNT_W'(SP))) sos_top_inst (
    .mclk(mclk), .rst(rst), .sys_ctrl_wr(sys_ctrl_wr), .sys_ctrl_wdata(sys_ctrl_wdata),
    .lxt_ctrl_wr(lxt_ctrl_wr), .lxt_ctrl_wdata(lxt_ctrl_wdata), .xt_pin_func_osc(xt_pin_func_osc),
    .halt(halt), .high_xtal_tick(ticks[3]), .high_rc_tick(ticks[2]), .low_xtal_tick(ticks[1]),
    .low_rc_tick(ticks[0]), .sys_ctrl(sys_ctrl), .lxt_ctrl(lxt_ctrl), .status(status),
    .sys_clk_en(sys_clk_en), .high_clk_en(high_clk_en), .low_clk_en(low_clk_en),
    .low_xtal_run(low_xtal_run));

  // free-running 40 MHz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // count clock enable pulses seen at each edge
  always @(posedge mclk) begin
    if (sys_clk_en === 1'b1) sys_cnt++;
    if (high_clk_en === 1'b1) hi_cnt++;
    if (low_clk_en === 1'b1) lo_cnt++;
  end

  // expected pulses from n ticks through a divide by 2^code
  function automatic int exp_div(input int code, input int ntk);
    return ntk >> code;
  endfunction : exp_div

  // build a control word, low idle bit left clear
  function automatic sos_sys_ctrl_s mk(input logic [2:0] sel, input logic hs, input logic ls, input logic hid);
    return {sel, hs, ls, hid, 1'b0};
  endfunction : mk

  // compare a register or flag value
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_val

  // compare a pulse count
  task automatic chk_cnt(input int got, input int exp, input string what);
    cmp_count++;
    if (got != exp) begin
      fail_count++;
      $display("BAD t=%0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask : chk_cnt

  // one-cycle write of the system control word
  task automatic wr_sys(input sos_sys_ctrl_s v);
    @(posedge mclk);
    sys_ctrl_wr <= 1'b1;
    sys_ctrl_wdata <= v;
    @(posedge mclk);
    sys_ctrl_wr <= 1'b0;
    #1;
  endtask : wr_sys

  // one-cycle write of the crystal control word
  task automatic wr_lxt(input sos_lxt_ctrl_s v);
    @(posedge mclk);
    lxt_ctrl_wr <= 1'b1;
    lxt_ctrl_wdata <= v;
    @(posedge mclk);
    lxt_ctrl_wr <= 1'b0;
    #1;
  endtask : wr_lxt

  // tick the masked sources every cycle for ntk cycles, then let pulses drain
  task automatic run_ticks(input logic [3:0] m, input int ntk);
    @(negedge mclk);
    sys_cnt = 0;
    hi_cnt = 0;
    lo_cnt = 0;
    repeat (ntk) begin
      @(posedge mclk);
      ticks <= m;
    end
    @(posedge mclk);
    ticks <= 4'h0;
    repeat (4) @(posedge mclk);
    #1;
  endtask : run_ticks

  // wait for the crystal ready status, bounded
  task automatic wait_ready(output int cyc);
    cyc = 0;
    while (status.low_xtal_ready !== 1'b1 && cyc < 200) begin
      @(posedge mclk);
      #1;
      cyc++;
    end
  endtask : wait_ready

  // print counts and the verdict, then stop
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize

  // watchdog against a hung run
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    summarize();
  end

  // main sequence
  initial begin
    {rst, sys_ctrl_wr, lxt_ctrl_wr, xt_pin_func_osc, halt} = 5'h10;
    sys_ctrl_wdata = '0;
    lxt_ctrl_wdata = '0;
    ticks = 4'h0;
    fail_count = 0;
    cmp_count = 0;
    seed = $urandom(32'h7546);
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk_val(8'(sys_ctrl.high_source_select), 8'(HS_XTAL), "reset high src");
    chk_val({1'b0, sys_ctrl}, 8'h00, "reset sys regs");
    chk_val({2'b00, lxt_ctrl, status}, 8'h00, "reset lxt and status");
    // random control words read back and steer status
    repeat (8) begin
      d = sos_sys_ctrl_s'($urandom);
      wr_sys(d);
      chk_val({1'b0, sys_ctrl}, {1'b0, d}, "readback");
      @(posedge mclk);
      #1;
      chk_val(8'(status.sys_on_low), 8'(d.sys_clk_select == SEL_LOW), "on low");
    end
    // every divide code on both high sources, the other source must not pass
    for (int c = 0; c < 7; c++) begin
      for (int h = 0; h < 2; h++) begin
        wr_sys(mk(3'(c), 1'(h), LS_RC, 1'b0));
        run_ticks(h ? 4'h4 : 4'h8, 128);
        chk_cnt(sys_cnt, exp_div(c, 128), "divided");
        chk_cnt(hi_cnt, 128, "high path");
        run_ticks(h ? 4'hB : 4'h7, 64);
        chk_cnt(sys_cnt, 0, "unselected high");
      end
    end
    // low path from the rc oscillator
    wr_sys(mk(SEL_LOW, HS_XTAL, LS_RC, 1'b0));
    run_ticks(4'h1, 20);
    chk_cnt(sys_cnt, 20, "low rc");
    run_ticks(4'hE, 20);
    chk_cnt(sys_cnt, 0, "low code ignores high");
    // halt gates the system clock, idle bit keeps the high clock
    wr_sys(mk(SEL_DIV1, HS_XTAL, LS_RC, 1'b0));
    @(posedge mclk);
    halt <= 1'b1;
    run_ticks(4'h9, 10);
    chk_cnt(sys_cnt + hi_cnt + lo_cnt, 0, "sleep");
    wr_sys(mk(SEL_DIV1, HS_XTAL, LS_RC, 1'b1));
    run_ticks(4'h8, 10);
    chk_cnt(sys_cnt * 100 + hi_cnt, 10, "idle high");
    // low idle bit alone keeps only the low clock through halt
    wr_sys({SEL_LOW, HS_XTAL, LS_RC, 1'b0, 1'b1});
    run_ticks(4'h9, 10);
    chk_cnt(sys_cnt * 100 + hi_cnt * 10 + lo_cnt, 10, "idle low");
    @(posedge mclk);
    halt <= 1'b0;
    // crystal pins withheld, then given; speed-up startup
    wr_sys(mk(SEL_DIV1, HS_XTAL, LS_XTAL, 1'b0));
    wr_lxt(2'b11);
    chk_val(8'(low_xtal_run), 8'h00, "pins as io");
    @(posedge mclk);
    xt_pin_func_osc <= 1'b1;
    #1;
    chk_val(8'(low_xtal_run), 8'h01, "pins to osc");
    wait_ready(n);
    chk_val(8'(n >= SP - 1 && n <= SP + 3), 8'h01, "speed-up start");
    chk_val(8'(status.xt_pins_osc), 8'h01, "pin status");
    wr_lxt(2'b00);
    repeat (2) @(posedge mclk);
    #1;
    chk_val(8'(status.low_xtal_ready), 8'h00, "ready drops");
    wr_lxt(2'b01);
    wait_ready(n);
    chk_val(8'(n >= LP - 1 && n <= LP + 3), 8'h01, "low-power start");
    // mode set first, then crystal selected; ticks held until ready
    wr_lxt(2'b00);
    repeat (2) @(posedge mclk);
    wr_lxt(2'b01);
    wr_sys(mk(SEL_LOW, HS_XTAL, LS_XTAL, 1'b0));
    run_ticks(4'h2, 4);
    chk_cnt(sys_cnt, 0, "crystal not ready");
    wait_ready(n);
    run_ticks(4'h2, 8);
    chk_cnt(sys_cnt + lo_cnt, 16, "crystal ticks");
    // mode bit frozen while the crystal clocks the system
    wr_lxt(2'b11);
    chk_val(8'(lxt_ctrl), 8'h01, "locked mode");
    chk_val(8'(status.mode_locked), 8'h01, "lock status");
    wr_sys(mk(SEL_DIV1, HS_XTAL, LS_XTAL, 1'b0));
    wr_lxt(2'b11);
    chk_val(8'(lxt_ctrl), 8'h03, "unlocked mode");
    summarize();
  end
endmodule : system_oscillator_select_bench
